// ### msr_regfile.sv
// Special register file: program counter, indirect window, timer, status, port, flags, storage.
// Assumes a core on msr_core_if and port pins resolved outside from pb_out_o and pb_oe_o.
`timescale 1ns/1ns
`default_nettype none
`include "msr_params.svh"

// Operation
// - Ten-bit program counter over 1K words
// - Vectors: reset 000, software 001, hardware 008
// - Address 00 redirects through the pointer
// - Pointer low six bits select 64 locations
// - Pointer upper two bits read as one
// - Timer counts pin edges or cycles, read/write
// - Low byte advances unless asleep, vectored by an interrupt, branched or written
// - Low-byte write: A9 from page, A8 cleared
// - Carry and half carry from add/subtract
// - Zero flag follows result being zero
// - Power-down flag: set clear-watchdog, cleared sleep
// - Expiry flag: set clear/sleep, cleared on overflow
// - Status bit 5 selects program page
// - Status bit 6 is free read/write
// - Status bit 7 marks port-change wake
// - Port data register drives only the pins whose direction bit is 0
// - Timer overflow flag sticky until cleared
// - Port change flag sticky until cleared
// - External pin flag sticky until cleared
// - Watchdog interrupt flag sticky until cleared
// - Locations 10 to 3F are plain storage
// - Count edge selectable rising or falling
module msr_regfile
   import msr_pkg::*;
(
   input wire logic core_clk_i,          // Instruction cycle clock
   input wire logic rstn_i,              // Asynchronous reset, active low
   msr_core_if.dev bus,                  // Core side
   input wire logic [7:0] pb_in_i,       // Port pin levels
   output logic [7:0] pb_out_o,          // Port output data
   output logic [7:0] pb_oe_o,           // Port output enables, high drives
   input wire logic [7:0] pb_dir_i,      // Pin direction, 1 = input
   input wire logic [7:0] pb_change_en_i, // Per-pin change detect enable
   input wire logic tmr_src_pin_i,       // Timer source, 1 = count pin
   input wire logic count_edge_select_i, // 0 = rising, 1 = falling count edge
   input wire logic ext_edge_rise_i,     // External pin edge, 1 = rising
   input wire logic wdt_overflow_i,      // Watchdog overflow pulse
   input wire logic wdt_irq_i,           // Watchdog interrupt pulse
   output logic [7:0] irq_flags_o        // Interrupt flags
);
   msr_pc_t pc, next_pc;
   logic [7:0] timer, next_timer;
   logic [7:0] status, next_status;
   logic [5:0] ptr, next_ptr;
   logic [7:0] port_latch, next_port_latch;
   logic [7:0] irq, next_irq;
   logic [7:0] pin_prev, next_pin_prev;
   logic [7:0] rdata, next_rdata;
   msr_pwr_t pwr, next_pwr;
   logic [7:0] ram [`MSR_RAM_LO:`MSR_RAM_HI];

   logic [5:0] eff_addr;
   logic [7:0] rd_val;
   logic cnt_rise, cnt_fall, ext_rise, ext_fall;
   logic tmr_tick, tmr_ovf, port_chg, ext_evt, wake;
   logic wr_timer, wr_pcl, wr_status, wr_ptr, wr_port, wr_irq, wr_ram;

   // Address decode and read mux
   always_comb begin
      eff_addr = (bus.addr == `MSR_A_INDIR) ? ptr : bus.addr;
      wr_timer = bus.wr && (eff_addr == `MSR_A_TIMER);
      wr_pcl = bus.wr && (eff_addr == `MSR_A_PCL);
      wr_status = bus.wr && (eff_addr == `MSR_A_STATUS);
      wr_ptr = bus.wr && (eff_addr == `MSR_A_PTR);
      wr_port = bus.wr && (eff_addr == `MSR_A_PORT);
      wr_irq = bus.wr && (eff_addr == `MSR_A_IRQ);
      wr_ram = bus.wr && (eff_addr >= `MSR_RAM_LO);
      rd_val = `MSR_BYTE_ZERO;
      if (eff_addr >= `MSR_RAM_LO) begin
         rd_val = ram[eff_addr];
      end else begin
         unique case (eff_addr)
            // A pointer aimed at the window itself reads zero, since no storage is there
            `MSR_A_INDIR: rd_val = `MSR_BYTE_ZERO;
            `MSR_A_TIMER: rd_val = timer;
            `MSR_A_PCL: rd_val = pc[7:0];
            `MSR_A_STATUS: rd_val = status;
            `MSR_A_PTR: rd_val = {`MSR_PTR_PAD, ptr};
            `MSR_A_PORT: rd_val = pb_in_i;
            `MSR_A_IRQ: rd_val = irq & `MSR_IRQ_MASK;
            default: rd_val = `MSR_BYTE_ZERO;
         endcase
      end
   end

   // Pin edges and events
   always_comb begin
      next_pin_prev = pb_in_i;
      cnt_rise = pb_in_i[`MSR_CNT_PIN] & ~pin_prev[`MSR_CNT_PIN];
      cnt_fall = ~pb_in_i[`MSR_CNT_PIN] & pin_prev[`MSR_CNT_PIN];
      ext_rise = pb_in_i[`MSR_EXT_PIN] & ~pin_prev[`MSR_EXT_PIN];
      ext_fall = ~pb_in_i[`MSR_EXT_PIN] & pin_prev[`MSR_EXT_PIN];
      // The instruction clock stops in sleep, so only pin edges count there
      if (tmr_src_pin_i) begin
         tmr_tick = count_edge_select_i ? cnt_fall : cnt_rise;
      end else begin
         tmr_tick = (pwr == MSR_RUN);
      end
      tmr_ovf = tmr_tick && !wr_timer && (timer == `MSR_TMR_MAX);
      port_chg = |((pb_in_i ^ pin_prev) & pb_change_en_i & pb_dir_i);
      ext_evt = ext_edge_rise_i ? ext_rise : ext_fall;
      wake = (pwr == MSR_SLEEP) &&
             (port_chg || ext_evt || wdt_irq_i || wdt_overflow_i || bus.hw_int);
   end

   // Next state of all registers but the pin history and storage
   always_comb begin
      next_rdata = bus.rd ? rd_val : rdata;
      next_ptr = wr_ptr ? bus.wdata[5:0] : ptr;
      next_port_latch = wr_port ? bus.wdata : port_latch;
      if (wr_timer) begin
         next_timer = bus.wdata;
      end else if (tmr_tick) begin
         next_timer = timer + `MSR_TMR_ONE;
      end else begin
         next_timer = timer;
      end

      next_pwr = pwr;
      if (bus.sleep_ins) begin
         next_pwr = MSR_SLEEP;
      end else if (wake) begin
         next_pwr = MSR_RUN;
      end

      if (pwr == MSR_SLEEP) begin
         next_pc = pc;
      end else if (bus.hw_int) begin
         next_pc = `MSR_VEC_HWINT;
      end else if (bus.sw_int) begin
         next_pc = `MSR_VEC_SWINT;
      end else if (bus.branch) begin
         next_pc = bus.branch_target;
      end else if (wr_pcl) begin
         next_pc = {status[`MSR_ST_PAGE], 1'b0, bus.wdata};
      end else begin
         next_pc = pc + `MSR_PC_ONE;
      end

      next_status = status;
      if (wr_status) begin
         next_status[`MSR_ST_C] = bus.wdata[`MSR_ST_C];
         next_status[`MSR_ST_DC] = bus.wdata[`MSR_ST_DC];
         next_status[`MSR_ST_Z] = bus.wdata[`MSR_ST_Z];
         next_status[`MSR_ST_PAGE] = bus.wdata[`MSR_ST_PAGE];
         next_status[`MSR_ST_GP] = bus.wdata[`MSR_ST_GP];
         next_status[`MSR_ST_WAKE] = status[`MSR_ST_WAKE] & bus.wdata[`MSR_ST_WAKE];
      end
      if (bus.alu_upd) begin
         next_status[`MSR_ST_C] = bus.alu_cout;
         next_status[`MSR_ST_DC] = bus.alu_hcout;
         next_status[`MSR_ST_Z] = (bus.alu_res == `MSR_BYTE_ZERO);
      end
      if (bus.watchdog_clear_instruction_ins) begin
         next_status[`MSR_ST_PD] = 1'b1;
         next_status[`MSR_ST_TO] = 1'b1;
      end else if (bus.sleep_ins) begin
         next_status[`MSR_ST_PD] = 1'b0;
         next_status[`MSR_ST_TO] = 1'b1;
      end
      if (wdt_overflow_i) begin
         next_status[`MSR_ST_TO] = 1'b0;
      end
      if (wake && port_chg) begin
         next_status[`MSR_ST_WAKE] = 1'b1;
      end

      // Writing one leaves a flag alone; a same-cycle hardware set beats the clear
      next_irq = wr_irq ? (irq & bus.wdata & `MSR_IRQ_MASK) : irq;
      if (tmr_ovf) begin
         next_irq[`MSR_IF_TMR] = 1'b1;
      end
      if (port_chg) begin
         next_irq[`MSR_IF_PORT] = 1'b1;
      end
      if (ext_evt) begin
         next_irq[`MSR_IF_EXT] = 1'b1;
      end
      if (wdt_irq_i) begin
         next_irq[`MSR_IF_WDT] = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pc <= `MSR_VEC_RESET;
         timer <= `MSR_BYTE_ZERO;
         status <= `MSR_STATUS_RST;
         ptr <= `MSR_PTR_RST;
         port_latch <= `MSR_BYTE_ZERO;
         irq <= `MSR_BYTE_ZERO;
         pin_prev <= `MSR_BYTE_ZERO;
         rdata <= `MSR_BYTE_ZERO;
         pwr <= MSR_RUN;
      end else begin
         pc <= next_pc;
         timer <= next_timer;
         status <= next_status;
         ptr <= next_ptr;
         port_latch <= next_port_latch;
         irq <= next_irq;
         pin_prev <= next_pin_prev;
         rdata <= next_rdata;
         pwr <= next_pwr;
      end
   end

   // Storage has no reset, as in the real array
   always_ff @(posedge core_clk_i) begin
      if (wr_ram) begin
         ram[eff_addr] <= bus.wdata;
      end
   end

   assign bus.rdata = rdata;
   assign bus.pc = pc;
   assign bus.asleep = (pwr == MSR_SLEEP);
   assign pb_out_o = port_latch;
   assign pb_oe_o = ~pb_dir_i;
   assign irq_flags_o = irq;
endmodule : msr_regfile
`default_nettype wire

// ### msr_params.svh
// Constants of the special register file: addresses, bit positions, vectors, reset values.
// Assumes it is included by bare name wherever the names are needed.
`ifndef MSR_PARAMS_SVH
`define MSR_PARAMS_SVH

`define MSR_A_INDIR   6'h00
`define MSR_A_TIMER   6'h01
`define MSR_A_PCL     6'h02
`define MSR_A_STATUS  6'h03
`define MSR_A_PTR     6'h04
`define MSR_A_PORT    6'h06
`define MSR_A_IRQ     6'h0F
`define MSR_RAM_LO    6'h10
`define MSR_RAM_HI    6'h3F

`define MSR_ST_C      3'h0
`define MSR_ST_DC     3'h1
`define MSR_ST_Z      3'h2
`define MSR_ST_PD     3'h3
`define MSR_ST_TO     3'h4
`define MSR_ST_PAGE   3'h5
`define MSR_ST_GP     3'h6
`define MSR_ST_WAKE   3'h7
`define MSR_STATUS_RST 8'h18

`define MSR_IF_TMR    3'h0
`define MSR_IF_PORT   3'h1
`define MSR_IF_EXT    3'h2
`define MSR_IF_WDT    3'h6
`define MSR_IRQ_MASK  8'h47

`define MSR_PTR_PAD   2'h3
`define MSR_PTR_RST   6'h00
`define MSR_TMR_ONE   8'h01
`define MSR_VEC_RESET 10'h000
`define MSR_VEC_SWINT 10'h001
`define MSR_VEC_HWINT 10'h008
`define MSR_PC_ONE    10'h001
`define MSR_TMR_MAX   8'hFF
`define MSR_BYTE_ZERO 8'h00
`define MSR_CNT_PIN   3'h2
`define MSR_EXT_PIN   3'h0

`endif

// ### msr_pkg.sv
// Types and the shared ALU helper of the special register file.
// Assumes msr_params.svh is reachable on the include path.
package msr_pkg;
   typedef logic [9:0] msr_pc_t;

   typedef enum logic {
      MSR_RUN   = 1'b0,
      MSR_SLEEP = 1'b1
   } msr_pwr_t;

   // Returns {half carry, carry, result}; on subtract both carries mean no borrow
   function automatic logic [9:0] msr_alu(input logic [7:0] a, input logic [7:0] b,
                                          input logic sub);
      logic [7:0] bb;
      logic [8:0] sum;
      logic [4:0] nib;
      bb = sub ? ~b : b;
      sum = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
      nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
      return {nib[4], sum[8], sum[7:0]};
   endfunction : msr_alu
endpackage : msr_pkg

// ### msr_core_if.sv
// Link between the execution core and the special register file.
// Assumes one clock shared by both ends; no clocking block.
`timescale 1ns/1ns
`default_nettype none
interface msr_core_if;
   logic [5:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic alu_upd;
   logic alu_cout;
   logic alu_hcout;
   logic [7:0] alu_res;
   logic sleep_ins;
   logic watchdog_clear_instruction_ins;
   logic sw_int;
   logic hw_int;
   logic branch;
   logic [9:0] branch_target;
   logic [9:0] pc;
   logic asleep;

   modport dev (
      input addr, wdata, wr, rd, alu_upd, alu_cout, alu_hcout, alu_res,
      input sleep_ins, watchdog_clear_instruction_ins, sw_int, hw_int, branch, branch_target,
      output rdata, pc, asleep
   );
   modport core (
      output addr, wdata, wr, rd, alu_upd, alu_cout, alu_hcout, alu_res,
      output sleep_ins, watchdog_clear_instruction_ins, sw_int, hw_int, branch, branch_target,
      input rdata, pc, asleep
   );
endinterface : msr_core_if
`default_nettype wire

// ### msr_core_end.sv
// Execution-core end: turns plain commands into register file accesses and ALU updates.
// Assumes msr_regfile on the other side of msr_core_if, same clock.
`timescale 1ns/1ns
`default_nettype none
`include "msr_params.svh"
module msr_core_end
   import msr_pkg::*;
(
   input wire logic core_clk_i,         // Instruction cycle clock
   input wire logic rstn_i,             // Asynchronous reset, active low
   msr_core_if.core bus,                // Register file side
   input wire logic [5:0] cmd_addr_i,   // Data address
   input wire logic [7:0] cmd_wdata_i,  // Write data
   input wire logic cmd_wr_i,           // Write strobe
   input wire logic cmd_rd_i,           // Read strobe
   output logic [7:0] cmd_rdata_o,      // Read data, cycle after the read
   input wire logic cmd_alu_i,          // ALU op, result written to cmd_addr_i
   input wire logic cmd_sub_i,          // 1 = subtract, 0 = add
   input wire logic [7:0] op_a_i,       // First operand
   input wire logic [7:0] op_b_i,       // Second operand
   input wire logic cmd_sleep_i,        // Sleep instruction
   input wire logic cmd_watchdog_clear_instruction_i,       // Watchdog-clear instruction
   input wire logic cmd_swint_i,        // Software interrupt instruction
   input wire logic cmd_hwint_i,        // Hardware interrupt taken
   input wire logic cmd_jump_i,         // Branch
   input wire logic [9:0] cmd_target_i, // Branch target
   output logic [9:0] pc_o,             // Program counter
   output logic asleep_o                // Core is asleep
);
   logic [9:0] alu_out;

   // Commands pass straight through so read data keep their one-cycle latency
   always_comb begin
      alu_out = msr_alu(op_a_i, op_b_i, cmd_sub_i);
      bus.addr = cmd_addr_i;
      bus.wr = cmd_wr_i | cmd_alu_i;
      bus.wdata = cmd_alu_i ? alu_out[7:0] : cmd_wdata_i;
      bus.rd = cmd_rd_i;
      bus.alu_upd = cmd_alu_i;
      bus.alu_res = alu_out[7:0];
      bus.alu_cout = alu_out[8];
      bus.alu_hcout = alu_out[9];
      bus.sleep_ins = cmd_sleep_i;
      bus.watchdog_clear_instruction_ins = cmd_watchdog_clear_instruction_i;
      bus.sw_int = cmd_swint_i;
      bus.hw_int = cmd_hwint_i;
      bus.branch = cmd_jump_i;
      bus.branch_target = cmd_target_i;
      cmd_rdata_o = bus.rdata;
      pc_o = bus.pc;
      asleep_o = bus.asleep;
   end
endmodule : msr_core_end
`default_nettype wire

// ### msr_link_assertions.sv
// Checker for the link between the core end and the special register file.
// Assumes it sits beside msr_core_if and sees its signals as plain inputs.
`timescale 1ns/1ns
`default_nettype none
module msr_link_assertions (
   input wire logic core_clk_i,          // Clock
   input wire logic rstn_i,              // Reset, low
   input wire logic [5:0] addr,          // Address
   input wire logic [7:0] wdata,         // Write data
   input wire logic wr,                  // Write strobe
   input wire logic rd,                  // Read strobe
   input wire logic [7:0] rdata,         // Read data
   input wire logic sleep_ins,           // Sleep pulse
   input wire logic sw_int,              // Soft interrupt
   input wire logic hw_int,              // Hard interrupt
   input wire logic branch,              // Branch pulse
   input wire logic [9:0] branch_target, // Target
   input wire logic [9:0] pc,            // Program counter
   input wire logic asleep               // Sleep state
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   // Sampled reset keeps the release edge itself out, where pc has not yet stepped
   sequence s_awake;
      rstn_i && !asleep && !hw_int && !sw_int;
   endsequence
   sequence s_jump;
      s_awake ##0 branch;
   endsequence

   property p_reset_vec;
      $rose(rstn_i) |-> pc == 10'h000;
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("pc not zero after reset");
   property p_hw_vec;
      !asleep && hw_int |=> pc == 10'h008;
   endproperty
   a_hw_vec: assert property (p_hw_vec) else $error("hardware vector wrong");
   property p_sw_vec;
      !asleep && !hw_int && sw_int |=> pc == 10'h001;
   endproperty
   a_sw_vec: assert property (p_sw_vec) else $error("software vector wrong");
   property p_branch;
      s_jump |=> pc == $past(branch_target);
   endproperty
   a_branch: assert property (p_branch) else $error("branch target not taken");
   property p_step;
      s_awake ##0 (!branch && !wr && !sleep_ins) |=> pc == 10'($past(pc) + 10'h001);
   endproperty
   a_step: assert property (p_step) else $error("pc did not advance by one");
   property p_pcl_wr;
      s_awake ##0 (!branch && wr && addr == 6'h02) |=> !pc[8] && pc[7:0] == $past(wdata);
   endproperty
   a_pcl_wr: assert property (p_pcl_wr) else $error("low byte write wrong");
   property p_sleep_hold;
      asleep && !hw_int |=> pc == $past(pc);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("pc moved while asleep");
   property p_sleep_entry;
      !asleep && !hw_int && sleep_ins |=> asleep;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
   property p_ptr_pad;
      rd && addr == 6'h04 |=> rdata[7:6] == 2'h3;
   endproperty
   a_ptr_pad: assert property (p_ptr_pad) else $error("pointer top bits not one");
   property p_rd_hold;
      !rd |=> rdata == $past(rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
endmodule : msr_link_assertions
`default_nettype wire

// ### tb_mcu_special_register_file.sv
// Testbench: core end and special register file joined by msr_core_if.
// Assumes one clock; port pin levels are resolved here from the enables.
`timescale 1ns/1ns
`default_nettype none
module tb_mcu_special_register_file;
   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [7:0] wdata = 8'h00, op_a = 8'h00, op_b = 8'h00, ext = 8'h00, dir = 8'hFF;
   logic [7:0] chg = 8'h00, ev = 8'h00, pout, poe, rdat, irqf;
   logic wr = 1'b0, rd = 1'b0, sub = 1'b0, tsrc = 1'b0, tedge = 1'b0, xrise = 1'b0;
   logic [9:0] target = 10'h000, pc, pc_hold;
   logic asleep;
   wire [7:0] pins;
   logic [7:0] ta [3] = '{8'hF8, 8'h05, 8'h03};
   logic [7:0] tb_op [3] = '{8'h08, 8'h03, 8'h05};
   logic [7:0] tst [3] = '{8'h1F, 8'h1B, 8'h18};
   logic [7:0] tres [3] = '{8'h00, 8'h02, 8'hFE};
   int fails = 0, samples_checked = 0, cyc = 0;
   assign pins = (poe & pout) | (~poe & ext);
   msr_core_if bus ();
   msr_regfile u_msr_regfile (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .bus(bus),
      .pb_in_i(pins), .pb_out_o(pout), .pb_oe_o(poe), .pb_dir_i(dir), .pb_change_en_i(chg),
      .tmr_src_pin_i(tsrc), .count_edge_select_i(tedge), .ext_edge_rise_i(xrise),
      .wdt_overflow_i(ev[5]), .wdt_irq_i(ev[6]), .irq_flags_o(irqf));
   msr_core_end u_msr_core_end (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .bus(bus),
      .cmd_addr_i(addr), .cmd_wdata_i(wdata), .cmd_wr_i(wr), .cmd_rd_i(rd), .cmd_rdata_o(rdat),
      .cmd_alu_i(ev[7]), .cmd_sub_i(sub), .op_a_i(op_a), .op_b_i(op_b), .cmd_sleep_i(ev[0]),
      .cmd_watchdog_clear_instruction_i(ev[1]), .cmd_swint_i(ev[2]), .cmd_hwint_i(ev[3]), .cmd_jump_i(ev[4]),
      .cmd_target_i(target), .pc_o(pc), .asleep_o(asleep));
   msr_link_assertions u_msr_link_assertions (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata),
      .sleep_ins(bus.sleep_ins), .sw_int(bus.sw_int), .hw_int(bus.hw_int), .branch(bus.branch),
      .branch_target(bus.branch_target), .pc(bus.pc), .asleep(bus.asleep));

   task automatic check(input string n, input logic [9:0] seen, input logic [9:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk_i);
      wr <= 1'b0;
      #1;
   endtask : wr_reg
   task automatic rd_chk(input string n, input logic [5:0] a, input logic [7:0] exp);
      @(posedge core_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk_i);
      rd <= 1'b0;
      #1;
      check(n, {2'h0, rdat}, {2'h0, exp});
   endtask : rd_chk
   task automatic pulse(input logic [7:0] m);
      @(posedge core_clk_i);
      ev <= m;
      @(posedge core_clk_i);
      ev <= 8'h00;
      #1;
   endtask : pulse
   // Pin changes are given three cycles to pass the input sampling
   task automatic pin(input int i, input logic v);
      @(posedge core_clk_i);
      ext[i] <= v;
      repeat (3) @(posedge core_clk_i);
      #1;
   endtask : pin
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim

   initial forever #20 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         end_sim();
      end
   end

   initial begin
      repeat (3) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      rd_chk("status", 6'h03, 8'h18);
      rd_chk("pointer", 6'h04, 8'hC0);
      rd_chk("flags", 6'h0F, 8'h00);
      wr_reg(6'h04, 8'h15);
      rd_chk("pointer", 6'h04, 8'hD5);
      wr_reg(6'h00, 8'hA5);
      rd_chk("window", 6'h15, 8'hA5);
      wr_reg(6'h04, 8'hFF);
      wr_reg(6'h00, 8'h3C);
      rd_chk("top", 6'h3F, 8'h3C);
      wr_reg(6'h10, 8'h81);
      wr_reg(6'h04, 8'h10);
      rd_chk("window", 6'h00, 8'h81);
      wr_reg(6'h05, 8'hAA);
      rd_chk("unmapped", 6'h05, 8'h00);
      $display("addressing test done");
      wr_reg(6'h01, 8'hFD);
      rd_chk("timer", 6'h01, 8'hFE);
      repeat (3) @(posedge core_clk_i);
      tsrc <= 1'b1;
      rd_chk("overflow", 6'h0F, 8'h01);
      wr_reg(6'h0F, 8'h00);
      rd_chk("cleared", 6'h0F, 8'h00);
      wr_reg(6'h01, 8'h10);
      pin(2, 1'b1);
      pin(2, 1'b0);
      rd_chk("rise count", 6'h01, 8'h11);
      @(posedge core_clk_i);
      tedge <= 1'b1;
      pin(2, 1'b1);
      pin(2, 1'b0);
      rd_chk("fall count", 6'h01, 8'h12);
      $display("timer test done");
      @(posedge core_clk_i);
      dir <= 8'h0F;
      ext <= 8'h03;
      wr_reg(6'h06, 8'h5A);
      check("port out", {2'h0, pout}, 10'h05A);
      check("port enable", {2'h0, poe}, 10'h0F0);
      rd_chk("port in", 6'h06, 8'h53);
      @(posedge core_clk_i);
      chg <= 8'h08;
      xrise <= 1'b1;
      pin(0, 1'b0);
      wr_reg(6'h0F, 8'h00);
      pin(3, 1'b1);
      pin(0, 1'b1);
      pulse(8'h40);
      rd_chk("events", 6'h0F, 8'h46);
      check("flag out", {2'h0, irqf}, 10'h046);
      wr_reg(6'h0F, 8'h06);
      rd_chk("one kept", 6'h0F, 8'h06);
      @(posedge core_clk_i);
      xrise <= 1'b0;
      addr <= 6'h0F;
      wdata <= 8'h00;
      wr <= 1'b1;
      ev <= 8'h40;
      @(posedge core_clk_i);
      wr <= 1'b0;
      ev <= 8'h00;
      #1;
      rd_chk("set wins", 6'h0F, 8'h40);
      wr_reg(6'h0F, 8'h00);
      pin(0, 1'b0);
      rd_chk("fall event", 6'h0F, 8'h04);
      $display("port and event test done");
      for (int i = 0; i < 3; i++) begin
         @(posedge core_clk_i);
         addr <= 6'h10;
         op_a <= ta[i];
         op_b <= tb_op[i];
         sub <= (i > 0);
         pulse(8'h80);
         rd_chk("alu status", 6'h03, tst[i]);
         rd_chk("alu result", 6'h10, tres[i]);
      end
      wr_reg(6'h03, 8'h60);
      rd_chk("status rw", 6'h03, 8'h78);
      $display("status test done");
      wr_reg(6'h02, 8'h55);
      check("pc write", pc, 10'h255);
      @(posedge core_clk_i);
      target <= 10'h3A0;
      pulse(8'h10);
      check("branch", pc, 10'h3A0);
      @(posedge core_clk_i);
      #1;
      check("step", pc, 10'h3A1);
      @(posedge core_clk_i);
      target <= 10'h3FF;
      pulse(8'h10);
      @(posedge core_clk_i);
      #1;
      check("wrap", pc, 10'h000);
      pulse(8'h04);
      check("soft vector", pc, 10'h001);
      pulse(8'h08);
      check("hard vector", pc, 10'h008);
      pulse(8'h0C);
      check("both vectors", pc, 10'h008);
      pulse(8'h01);
      pc_hold = pc;
      check("asleep", {9'h000, asleep}, 10'h001);
      repeat (2) @(posedge core_clk_i);
      #1;
      check("pc held", pc, pc_hold);
      pin(3, 1'b0);
      check("awake", {9'h000, asleep}, 10'h000);
      rd_chk("wake status", 6'h03, 8'hF0);
      pulse(8'h02);
      rd_chk("clear status", 6'h03, 8'hF8);
      pulse(8'h20);
      rd_chk("expiry", 6'h03, 8'hE8);
      $display("program counter test done");
      end_sim();
   end
endmodule : tb_mcu_special_register_file
`default_nettype wire
